// ### verilog/spio_pkg.sv
// Package: register map, widths and reset values of the shared I/O port
package spio_pkg;
  localparam int          PORT_W        = 16;
  localparam logic [11:0] OFF_DIR       = 12'h000;
  localparam logic [11:0] OFF_LEVEL     = 12'h004;
  localparam logic [11:0] OFF_LATCH     = 12'h008;
  localparam logic [11:0] OFF_PERI_EN   = 12'h00C;
  localparam logic [11:0] OFF_IMPL      = 12'h010;
  localparam logic [15:0] DIR_RST       = 16'hFFFF;
  localparam logic [15:0] LATCH_RST     = 16'h0000;
  localparam logic [15:0] PERI_EN_RST   = 16'h0000;
  localparam logic [15:0] IMPL_MASK_DEF = 16'hFFFF;
  localparam logic [15:0] IN_ONLY_DEF   = 16'h0000;
  localparam int          SYNC_STAGES   = 2;
endpackage

// ### verilog/spio_sync.sv
// Two-flop synchroniser bank for the pin inputs
`timescale 1ns/1ns
module spio_sync
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [15:0]       d,
  output logic      [15:0]       q
);
  logic [15:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      meta_r <= 16'h0000;
      q      <= 16'h0000;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### verilog/spio_mux.sv
// Per-pin output ownership multiplexer pair
`timescale 1ns/1ns
module spio_mux
(
  input  wire logic [15:0] port_out,
  input  wire logic [15:0] port_oe,
  input  wire logic [15:0] peri_out,
  input  wire logic [15:0] peri_oe,
  input  wire logic [15:0] peri_owns,
  output logic      [15:0] mux_out,
  output logic      [15:0] mux_oe
);
  always_comb
  begin
    mux_out = (peri_owns & peri_out) | (~peri_owns & port_out);
    mux_oe  = (peri_owns & peri_oe)  | (~peri_owns & port_oe);
  end
endmodule

// ### verilog/spio_port.sv
// Shared parallel I/O port with APB register access
// Contract
// - Two muxes pick peripheral or port output
// - Active peripheral disables port driver, pin readable
// - Idle enabled peripheral leaves port in control
// - Direction bit one means input, zero output
// - Reset makes every pin an input
// - Latch register reads latch, writes latch
// - Level register reads pins, writes latch
// - Unimplemented bits disabled and read zero
// - Input-only shared pins stay port owned
// - Every signal pin is multiplexable; the input-only pins set in IN_ONLY are never handed to a peripheral here
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module spio_port
#(
  parameter logic [15:0] IMPL_MASK = spio_pkg::IMPL_MASK_DEF,
  parameter logic [15:0] IN_ONLY   = spio_pkg::IN_ONLY_DEF
)
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] pin_i,
  output logic      [15:0] pin_o,
  output logic      [15:0] pin_oe,
  input  wire logic [15:0] peri_out,
  input  wire logic [15:0] peri_drive,
  output logic      [15:0] peri_in
);
  logic [15:0] dir_r;
  logic [15:0] latch_r;
  logic [15:0] peri_en_r;
  logic [15:0] pin_sync;
  logic [15:0] peri_owns;
  logic [15:0] mux_out;
  logic [15:0] mux_oe;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_nxt;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = hit(paddr, spio_pkg::OFF_DIR)   ||
                   hit(paddr, spio_pkg::OFF_LEVEL) ||
                   hit(paddr, spio_pkg::OFF_LATCH) ||
                   hit(paddr, spio_pkg::OFF_PERI_EN) ||
                   hit(paddr, spio_pkg::OFF_IMPL);

  // Every pin, including ones that also serve a peripheral, is synchronised
  spio_sync u_sync
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (pin_i),
    .q       (pin_sync)
  );

  // Direction register; reset forces all pins to input
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      dir_r <= spio_pkg::DIR_RST;
    else if (wr_en && hit(paddr, spio_pkg::OFF_DIR))
      dir_r <= pwdata[15:0] | ~IMPL_MASK;
  end

  // Latch is written through either the latch or the level address
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      latch_r <= spio_pkg::LATCH_RST;
    else if (wr_en && (hit(paddr, spio_pkg::OFF_LATCH) ||
                       hit(paddr, spio_pkg::OFF_LEVEL)))
      latch_r <= pwdata[15:0] & IMPL_MASK;
  end

  // Peripheral enables; input-only pins can never be handed over
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      peri_en_r <= spio_pkg::PERI_EN_RST;
    else if (wr_en && hit(paddr, spio_pkg::OFF_PERI_EN))
      peri_en_r <= pwdata[15:0] & IMPL_MASK & ~IN_ONLY;
  end

  // Peripheral takes the pin only while enabled and actively driving
  assign peri_owns = peri_en_r & peri_drive & ~IN_ONLY;

  spio_mux u_mux
  (
    .port_out  (latch_r),
    .port_oe   (~dir_r & IMPL_MASK),
    .peri_out  (peri_out),
    .peri_oe   (peri_drive),
    .peri_owns (peri_owns),
    .mux_out   (mux_out),
    .mux_oe    (mux_oe)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pin_o   <= 16'h0000;
      pin_oe  <= 16'h0000;
      peri_in <= 16'h0000;
    end
    else
    begin
      pin_o   <= mux_out & IMPL_MASK;
      pin_oe  <= mux_oe & IMPL_MASK;
      peri_in <= pin_sync & IMPL_MASK;
    end
  end

  // Read mux; unimplemented bits read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      spio_pkg::OFF_DIR:     rd_nxt[15:0] = dir_r & IMPL_MASK;
      spio_pkg::OFF_LEVEL:   rd_nxt[15:0] = pin_sync & IMPL_MASK;
      spio_pkg::OFF_LATCH:   rd_nxt[15:0] = latch_r;
      spio_pkg::OFF_PERI_EN: rd_nxt[15:0] = peri_en_r;
      spio_pkg::OFF_IMPL:    rd_nxt[15:0] = IMPL_MASK;
      default:               rd_nxt = 32'h0000_0000;
    endcase
  end

  // Data captured in setup so the answer comes with zero wait states
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= rd_nxt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end
endmodule

// ### verif/spio_assertions.sv
// Checker for APB answer timing and pin path behaviour
`timescale 1ns/1ns
module spio_assertions
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
)
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] pin_i,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] peri_out,
  input wire logic [15:0] peri_drive,
  input wire logic [15:0] peri_in
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("ready late");
  chk_ready_idle: assert property (!(psel && !penable) |=> !pready)
    else $error("stray ready");
  chk_err_ready: assert property (pslverr |-> pready) else $error("lone err");
  chk_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("err data");
  chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper data");
  chk_reset_input: assert property ($rose(resetn) |-> pin_oe == 16'h0)
    else $error("drive at reset");
  // Missing bits never reach the peripherals, whatever the board shows
  chk_sync_delay: assert property (resetn [*4] |->
    peri_in == ($past(pin_i, 3) & IMPL_MASK)) else $error("sync delay");
  // A pin may only move after a register write or a peripheral change
  chk_out_cause: assert property (!(pready && pwrite) ##1
    $stable(peri_out) && $stable(peri_drive) |=>
    $stable(pin_o) && $stable(pin_oe)) else $error("pin moved");
endmodule
bind spio_port spio_assertions #(.IMPL_MASK(IMPL_MASK)) chk_u (.clk_sys,
  .resetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe, .peri_out,
  .peri_drive, .peri_in);

// ### verif/spio_pads.sv
// Board side: a pin shows the port drive, else the board's own level
`timescale 1ns/1ns
module spio_pads
(
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] board,
  output logic      [15:0] pin_i
);
  assign pin_i = (pin_o & pin_oe) | (board & ~pin_oe);
endmodule

// ### verif/tb_top.sv
// Testbench: random port set-ups compared with a bench model
`timescale 1ns/1ns
module tb_top;
  localparam logic [15:0] M = 16'h7FFF;
  localparam logic [15:0] I = 16'h0003;
  logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, rnd = 32'h38084D57;
  logic [15:0] pin_i, pin_o, pin_oe, peri_in, dir, pen, own, oe, v, lat;
  logic [15:0] peri_out = '0, peri_drive = '0, board = '0;
  int          n_mismatch = 0, check_count = 0;
  always #10 clk_sys = ~clk_sys;
  // Bit 15 left unimplemented so the disabled-bit path is exercised
  // Two input-only pins so the port keeps them even when handed over
  spio_port #(.IMPL_MASK(M), .IN_ONLY(I)) dut_u (.clk_sys, .resetn, .psel,
    .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o,
    .pin_oe, .peri_out, .peri_drive, .peri_in);
  spio_pads pads_u (.pin_o, .pin_oe, .board, .pin_i);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, x);
    check_count++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1 && ++n < 20);
    if (pready !== 1'h1)
      n_mismatch++;
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    apb(0, spio_pkg::OFF_DIR, 0);
    chk("dir", r, {16'h0, spio_pkg::DIR_RST & M});
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      lat = rnd[15:0] & M;
      apb(1, i[0] ? spio_pkg::OFF_LEVEL : spio_pkg::OFF_LATCH, rnd[15:0]);
      apb(0, spio_pkg::OFF_LATCH, 0);
      chk("latch", r, {16'h0, lat});
      dir = rnd[31:16] | ~M;
      apb(1, spio_pkg::OFF_DIR, rnd[31:16]);
      rnd = lfsr(rnd);
      pen = rnd[15:0];
      apb(1, spio_pkg::OFF_PERI_EN, pen);
      peri_out <= rnd[31:16];
      rnd = lfsr(rnd);
      peri_drive <= rnd[15:0];
      board <= rnd[31:16];
      repeat (6) @(posedge clk_sys);
      own = pen & rnd[15:0] & M & ~I;
      oe = (own | ~dir) & M;
      v = (own & peri_out) | (~own & lat);
      chk("oe", pin_oe, oe);
      chk("out", pin_o & oe, v & oe);
      apb(0, spio_pkg::OFF_LEVEL, 0);
      chk("level", r, {16'h0, ((v & oe) | (board & ~oe)) & M});
      $display("set-up %0d done", i);
    end
    apb(0, 12'h100, 16'hFFFF);
    chk("err", {31'h0, err}, 32'h1);
    chk("rdata", r, 32'h0);
    print_verdict;
  end
  initial
  begin
    #40000;
    n_mismatch++;
    print_verdict;
  end
endmodule
